// *** aopm_capture.sv ***
// capture receiver model latching a data word with its flag
// assumes data settle before the falling valid clock edge
module aopm_capture (
    // pins from the converter
    input wire logic        i_clk,
    input wire logic        i_oe_n,
    input wire logic [11:0] i_data,
    input wire logic        i_ovf,
    // captured word
    output logic     [12:0] o_word
);
    always @(negedge i_clk) if (!i_oe_n) o_word <= {i_ovf, i_data};
endmodule

// *** aopm_delay_line.sv ***
// small shift memory that holds conversion results in flight
// assumes one shift per encode cycle; output comes from a register
module aopm_delay_line #(
    parameter int WIDTH = 14,
    parameter int DEPTH = 5
) (
    // clock and reset
    input  wire logic             i_sys_clk,
    input  wire logic             i_reset,
    // shift port
    input  wire logic             i_shift,
    input  wire logic [WIDTH-1:0] i_data,
    output logic      [WIDTH-1:0] o_data
);
    logic [WIDTH-1:0] stage_r [DEPTH];

    always_ff @(posedge i_sys_clk) begin
        if (i_reset) begin
            for (int i = 0; i < DEPTH; i++) begin
                stage_r[i] <= '0;
            end
        end else if (i_shift) begin
            stage_r[0] <= i_data;
            for (int i = 1; i < DEPTH; i++) begin
                stage_r[i] <= stage_r[i-1];
            end
        end
    end

    assign o_data = stage_r[DEPTH-1];
endmodule

// *** aopm_pkg.sv ***
// constants shared by the converter output port block
// assumes a 10 MHz system clock and a 32-bit word register port
package aopm_pkg;
    localparam int DATA_W        = 12;
    localparam int LATENCY       = 5;
    localparam int SYNC_STAGES   = 2;
    localparam int ADDR_W        = 8;
    localparam int REG_W         = 32;

    // register byte offsets
    localparam logic [7:0] CTRL_OFS     = 8'h00;
    localparam logic [7:0] STATE_OFS    = 8'h04;
    localparam logic [7:0] INT_STAT_OFS = 8'h08;
    localparam logic [7:0] INT_MASK_OFS = 8'h0C;

    // control field positions
    localparam int CTRL_PDS_BIT  = 0;
    localparam int CTRL_OEL_BIT  = 1;
    localparam int CTRL_MODE_LSB = 2;
    localparam int CTRL_FMT_LSB  = 4;

    // reset values: outputs released, full-rate cmos, offset binary
    localparam logic       PDS_RST  = 1'b0;
    localparam logic       OEL_RST  = 1'b1;
    localparam logic [1:0] MODE_RST = 2'h0;
    localparam logic [1:0] FMT_RST  = 2'h0;

    // four-level output mode select
    localparam logic [1:0] MODE_FULL = 2'h0;
    localparam logic [1:0] MODE_SIM  = 2'h1;
    localparam logic [1:0] MODE_INTL = 2'h2;
    localparam logic [1:0] MODE_LVDS = 2'h3;

    // four-level format select
    localparam logic [1:0] FMT_OB_OFF = 2'h0;
    localparam logic [1:0] FMT_OB_ON  = 2'h1;
    localparam logic [1:0] FMT_TC_ON  = 2'h2;
    localparam logic [1:0] FMT_TC_OFF = 2'h3;

    // interrupt status bits
    localparam int IRQ_W         = 3;
    localparam int IRQ_SAMPLE    = 0;
    localparam int IRQ_OVERFLOW  = 1;
    localparam int IRQ_POWER     = 2;

    typedef enum logic [2:0] {
        PWR_NORMAL = 3'h1,
        PWR_NAP    = 3'h2,
        PWR_SLEEP  = 3'h4
    } aopm_pwr_t;
endpackage

// *** aopm_sync.sv ***
// two flip-flop synchroniser for a group of slow levels
// assumes inputs that are stable across several system clocks
module aopm_sync #(
    parameter int WIDTH = 1
) (
    // clock and reset
    input  wire logic             i_sys_clk,
    input  wire logic             i_reset,
    // levels
    input  wire logic [WIDTH-1:0] i_async,
    output logic      [WIDTH-1:0] o_sync
);
    logic [WIDTH-1:0] meta_r;

    always_ff @(posedge i_sys_clk) begin
        if (i_reset) begin
            meta_r <= '0;
            o_sync <= '0;
        end else begin
            meta_r <= i_async;
            o_sync <= meta_r;
        end
    end
endmodule

// *** aopm_top.sv ***
// output port, power state and mode control of a 12-bit converter
// assumes the encode pins and sample inputs come from outside the
// system clock domain; register port is same-domain logic
//
// Added by the designer: the placing of the registers and the plain strobed port.

// Behaviour
// [RULE1] conversion starts on encode rising edge
// [RULE2] result appears five encode cycles later
// [RULE3] normal run; enable low drives outputs
// [RULE4] power-down selects nap or sleep, outputs off
// [RULE5] output mode: full, simultaneous, interleaved, lvds
// [RULE6] format select sets coding and stabilizer
// [RULE7] two's complement inverts the top bit
// [RULE8] primary bus is 12 bits, msb high
// [RULE9] secondary bus released in full-rate mode
// [RULE10] primary overflow flag follows its sample
// [RULE11] secondary overflow flag, released in full-rate
// [RULE12] receiver latches primary on falling valid clock
// [RULE13] secondary latch edge depends on demux mode
// [RULE14] secondary valid clock driven in full-rate mode
// [RULE15] demux modes alternate samples between buses
// [RULE16] lvds receiver latches on falling positive leg
// [RULE17] lvds overflow pair follows current sample
module aopm_top #(
    parameter int DATA_W  = aopm_pkg::DATA_W,
    parameter int LATENCY = aopm_pkg::LATENCY
) (
    // clock and reset
    input  wire logic              i_sys_clk,
    input  wire logic              i_reset,
    // encode pins and sampled analog value
    input  wire logic              i_encode_true_in,
    input  wire logic              i_encode_comp_in,
    input  wire logic [DATA_W-1:0] i_sample_code,
    input  wire logic              i_sample_over,
    // register port
    input  wire logic [7:0]        i_addr,
    input  wire logic [31:0]       i_wr_data,
    input  wire logic              i_wr,
    input  wire logic              i_rd,
    output logic      [31:0]       o_rd_data,
    output logic                   o_irq,
    // primary cmos bus
    output logic      [DATA_W-1:0] o_primary_data_bus,
    output logic                   o_primary_overflow_flag,
    output logic                   o_primary_data_valid_clock,
    output logic                   o_primary_oe_n,
    // secondary cmos bus
    output logic      [DATA_W-1:0] o_secondary_data_bus,
    output logic                   o_secondary_overflow_flag,
    output logic                   o_secondary_oe_n,
    output logic                   o_secondary_data_valid_clock,
    output logic                   o_secondary_clk_oe_n,
    // lvds outputs
    output logic      [DATA_W-1:0] o_diff_data_pairs_p,
    output logic      [DATA_W-1:0] o_diff_data_pairs_n,
    output logic                   o_diff_overflow_pair_p,
    output logic                   o_diff_overflow_pair_n,
    output logic                   o_diff_data_valid_clock_p,
    output logic                   o_diff_data_valid_clock_n,
    output logic                   o_diff_oe_n,
    // stabilizer state
    output logic                   o_duty_stab_on
);
    localparam int SW = DATA_W + 3;
    localparam int PW = DATA_W + 2;

    // sampled inputs
    logic [SW-1:0]       sync_in;
    logic [SW-1:0]       sync_out;
    logic                enc_high;
    logic                enc_prev_r;
    logic                enc_rise;
    logic                enc_fall;
    logic [DATA_W-1:0]   smp_code;
    logic                smp_over;

    // control
    logic                power_down_select_r;
    logic                output_enable_low_r;
    logic [1:0]          out_mode_r;
    logic [1:0]          fmt_sel_r;
    aopm_pkg::aopm_pwr_t pwr_r;
    aopm_pkg::aopm_pwr_t pwr_nxt;
    logic                pwr_evt;
    logic                running;
    logic                drive_en;
    logic                two_comp;
    logic                wr_ctrl;
    logic                wr_stat;
    logic                wr_mask;

    // conversion pipeline and demux
    logic                conv_start;
    logic [PW-1:0]       pipe_in;
    logic [PW-1:0]       pipe_out;
    logic                half_sel_r;
    logic [PW-1:0]       held_r;

    // interrupts and read path
    logic [aopm_pkg::IRQ_W-1:0] int_stat_r;
    logic [aopm_pkg::IRQ_W-1:0] int_mask_r;
    logic [aopm_pkg::IRQ_W-1:0] int_evt;
    logic [31:0]                rd_word;

    // [RULE7] top bit inverted
    function automatic logic [DATA_W-1:0] fmt_code(
        input logic [DATA_W-1:0] code,
        input logic              tc
    );
        logic [DATA_W-1:0] top;
        top = '0;
        top[DATA_W-1] = tc;
        return code ^ top;
    endfunction

    function automatic logic is_lvds(input logic [1:0] mode);
        return mode == aopm_pkg::MODE_LVDS;
    endfunction

    function automatic logic is_demux(input logic [1:0] mode);
        return (mode == aopm_pkg::MODE_SIM) ||
               (mode == aopm_pkg::MODE_INTL);
    endfunction

    // encode legs and sample word cross together; the sample word is
    // expected to sit still around the encode edge
    assign sync_in = {i_encode_true_in, i_encode_comp_in, i_sample_over,
                      i_sample_code};

    aopm_sync #(.WIDTH(SW)) u_sync (
        .i_sys_clk (i_sys_clk),
        .i_reset   (i_reset),
        .i_async   (sync_in),
        .o_sync    (sync_out)
    );

    assign enc_high = sync_out[SW-1] & ~sync_out[SW-2];
    assign smp_over = sync_out[DATA_W];
    assign smp_code = sync_out[DATA_W-1:0];

    // [RULE1] encode edge detect
    // previous level resets low, the idle level of the encode pin
    always_ff @(posedge i_sys_clk) begin
        if (i_reset) begin
            enc_prev_r <= 1'b0;
        end else begin
            enc_prev_r <= enc_high;
        end
    end

    assign enc_rise   = enc_high & ~enc_prev_r;
    assign enc_fall   = ~enc_high & enc_prev_r;
    assign conv_start = enc_rise & running;

    // register port decode
    assign wr_ctrl = i_wr && (i_addr == aopm_pkg::CTRL_OFS);
    assign wr_stat = i_wr && (i_addr == aopm_pkg::INT_STAT_OFS);
    assign wr_mask = i_wr && (i_addr == aopm_pkg::INT_MASK_OFS);

    always_ff @(posedge i_sys_clk) begin
        if (i_reset) begin
            power_down_select_r <= aopm_pkg::PDS_RST;
            output_enable_low_r <= aopm_pkg::OEL_RST;
            out_mode_r          <= aopm_pkg::MODE_RST;
            fmt_sel_r           <= aopm_pkg::FMT_RST;
        end else if (wr_ctrl) begin
            power_down_select_r <= i_wr_data[aopm_pkg::CTRL_PDS_BIT];
            output_enable_low_r <= i_wr_data[aopm_pkg::CTRL_OEL_BIT];
            out_mode_r          <= i_wr_data[aopm_pkg::CTRL_MODE_LSB +: 2];
            fmt_sel_r           <= i_wr_data[aopm_pkg::CTRL_FMT_LSB +: 2];
        end
    end

    // [RULE3] [RULE4] power state decode
    always_comb begin
        case ({power_down_select_r, output_enable_low_r})
            2'h2: pwr_nxt = aopm_pkg::PWR_NAP;
            2'h3: pwr_nxt = aopm_pkg::PWR_SLEEP;
            default: pwr_nxt = aopm_pkg::PWR_NORMAL;
        endcase
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_reset) begin
            pwr_r <= aopm_pkg::PWR_NORMAL;
        end else begin
            pwr_r <= pwr_nxt;
        end
    end

    assign pwr_evt  = (pwr_nxt != pwr_r);
    assign running  = (pwr_r == aopm_pkg::PWR_NORMAL);
    assign drive_en = running & ~output_enable_low_r;
    // [RULE6] format select coding
    assign two_comp = (fmt_sel_r == aopm_pkg::FMT_TC_ON) ||
                      (fmt_sel_r == aopm_pkg::FMT_TC_OFF);

    // [RULE3] [RULE4] [RULE5] output enables per mode
    // [RULE9] [RULE11] secondary released outside demux
    // [RULE14] secondary clock driven in every cmos mode, released in lvds mode
    always_ff @(posedge i_sys_clk) begin
        if (i_reset) begin
            o_primary_oe_n       <= 1'b1;
            o_secondary_oe_n     <= 1'b1;
            o_secondary_clk_oe_n <= 1'b1;
            o_diff_oe_n          <= 1'b1;
        end else begin
            o_primary_oe_n       <= ~(drive_en & ~is_lvds(out_mode_r));
            o_secondary_oe_n     <= ~(drive_en & is_demux(out_mode_r));
            o_secondary_clk_oe_n <= ~(drive_en & ~is_lvds(out_mode_r));
            o_diff_oe_n          <= ~(drive_en & is_lvds(out_mode_r));
        end
    end

    // [RULE6] stabilizer from format select
    always_ff @(posedge i_sys_clk) begin
        if (i_reset) begin
            o_duty_stab_on <= 1'b0;
        end else begin
            o_duty_stab_on <= (fmt_sel_r == aopm_pkg::FMT_OB_ON) ||
                              (fmt_sel_r == aopm_pkg::FMT_TC_ON);
        end
    end

    // [RULE2] five encode cycles latency
    // top bit marks a real sample so an unfilled pipe shows nothing
    assign pipe_in = {1'b1, smp_over, smp_code};

    aopm_delay_line #(.WIDTH(PW), .DEPTH(LATENCY)) u_pipe (
        .i_sys_clk (i_sys_clk),
        .i_reset   (i_reset),
        .i_shift   (conv_start),
        .i_data    (pipe_in),
        .o_data    (pipe_out)
    );

    // [RULE15] half-rate selector and held sample
    always_ff @(posedge i_sys_clk) begin
        if (i_reset) begin
            half_sel_r <= 1'b0;
            held_r     <= '0;
        end else if (conv_start) begin
            half_sel_r <= ~half_sel_r;
            if (!half_sel_r) held_r <= pipe_out;
        end
    end

    // [RULE8] [RULE10] primary bus update
    always_ff @(posedge i_sys_clk) begin
        if (i_reset) begin
            o_primary_data_bus      <= '0;
            o_primary_overflow_flag <= 1'b0;
        end else if (conv_start && pipe_out[PW-1] &&
                     (!is_demux(out_mode_r) || half_sel_r)) begin
            o_primary_data_bus      <= fmt_code(pipe_out[DATA_W-1:0],
                                                two_comp);
            o_primary_overflow_flag <= pipe_out[DATA_W];
        end
    end

    // [RULE9] [RULE11] [RULE15] secondary takes other samples
    always_ff @(posedge i_sys_clk) begin
        if (i_reset) begin
            o_secondary_data_bus      <= '0;
            o_secondary_overflow_flag <= 1'b0;
        end else if (conv_start) begin
            if (out_mode_r == aopm_pkg::MODE_INTL && !half_sel_r &&
                pipe_out[PW-1]) begin
                o_secondary_data_bus      <= fmt_code(
                    pipe_out[DATA_W-1:0], two_comp);
                o_secondary_overflow_flag <= pipe_out[DATA_W];
            end else if (out_mode_r == aopm_pkg::MODE_SIM &&
                         half_sel_r && held_r[PW-1]) begin
                o_secondary_data_bus      <= fmt_code(
                    held_r[DATA_W-1:0], two_comp);
                o_secondary_overflow_flag <= held_r[DATA_W];
            end
        end
    end

    // valid clocks rise with new data so a falling-edge latch lands
    // mid-word, except the secondary in simultaneous mode, which falls with new data; in demux modes they run at half rate
    // [RULE14] secondary clock keeps running
    always_ff @(posedge i_sys_clk) begin
        if (i_reset) begin
            o_primary_data_valid_clock   <= 1'b0;
            o_secondary_data_valid_clock <= 1'b0;
        end else if (is_demux(out_mode_r)) begin
            if (conv_start) begin
                o_primary_data_valid_clock   <= half_sel_r;
                o_secondary_data_valid_clock <= ~half_sel_r;
            end
        end else if (conv_start) begin
            o_primary_data_valid_clock   <= 1'b1;
            o_secondary_data_valid_clock <= 1'b1;
        end else if (enc_fall) begin
            o_primary_data_valid_clock   <= 1'b0;
            o_secondary_data_valid_clock <= 1'b0;
        end
    end

    // [RULE17] lvds legs, always complementary
    always_ff @(posedge i_sys_clk) begin
        if (i_reset) begin
            o_diff_data_pairs_p    <= '0;
            o_diff_data_pairs_n    <= '1;
            o_diff_overflow_pair_p <= 1'b0;
            o_diff_overflow_pair_n <= 1'b1;
        end else if (conv_start && pipe_out[PW-1]) begin
            o_diff_data_pairs_p    <= fmt_code(pipe_out[DATA_W-1:0],
                                               two_comp);
            o_diff_data_pairs_n    <= ~fmt_code(pipe_out[DATA_W-1:0],
                                                two_comp);
            o_diff_overflow_pair_p <= pipe_out[DATA_W];
            o_diff_overflow_pair_n <= ~pipe_out[DATA_W];
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_reset) begin
            o_diff_data_valid_clock_p <= 1'b0;
            o_diff_data_valid_clock_n <= 1'b1;
        end else if (conv_start) begin
            o_diff_data_valid_clock_p <= 1'b1;
            o_diff_data_valid_clock_n <= 1'b0;
        end else if (enc_fall) begin
            o_diff_data_valid_clock_p <= 1'b0;
            o_diff_data_valid_clock_n <= 1'b1;
        end
    end

    // [RULE10] sticky events, set wins
    assign int_evt[aopm_pkg::IRQ_SAMPLE]   = conv_start & pipe_out[PW-1];
    assign int_evt[aopm_pkg::IRQ_OVERFLOW] = conv_start & pipe_out[PW-1] &
                                             pipe_out[DATA_W];
    assign int_evt[aopm_pkg::IRQ_POWER]    = pwr_evt;

    always_ff @(posedge i_sys_clk) begin
        if (i_reset) begin
            int_stat_r <= '0;
        end else if (wr_stat) begin
            int_stat_r <= (int_stat_r &
                           ~i_wr_data[aopm_pkg::IRQ_W-1:0]) | int_evt;
        end else begin
            int_stat_r <= int_stat_r | int_evt;
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_reset) begin
            int_mask_r <= '0;
        end else if (wr_mask) begin
            int_mask_r <= i_wr_data[aopm_pkg::IRQ_W-1:0];
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_reset) begin
            o_irq <= 1'b0;
        end else begin
            o_irq <= |(int_stat_r & int_mask_r);
        end
    end

    // read mux; data stand only in the cycle after the strobe
    always_comb begin
        rd_word = '0;
        case (i_addr)
            aopm_pkg::CTRL_OFS: begin
                rd_word[aopm_pkg::CTRL_PDS_BIT]       = power_down_select_r;
                rd_word[aopm_pkg::CTRL_OEL_BIT]       = output_enable_low_r;
                rd_word[aopm_pkg::CTRL_MODE_LSB +: 2] = out_mode_r;
                rd_word[aopm_pkg::CTRL_FMT_LSB +: 2]  = fmt_sel_r;
            end
            aopm_pkg::STATE_OFS: rd_word[2:0] = pwr_r;
            aopm_pkg::INT_STAT_OFS: rd_word[aopm_pkg::IRQ_W-1:0] = int_stat_r;
            aopm_pkg::INT_MASK_OFS: rd_word[aopm_pkg::IRQ_W-1:0] = int_mask_r;
            default: rd_word = '0;
        endcase
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_reset) begin
            o_rd_data <= '0;
        end else begin
            o_rd_data <= i_rd ? rd_word : '0;
        end
    end
endmodule

// *** aopm_top_sva.sv ***
// pin level assertions for the converter output port block
// assumes the sys clock domain only; bound to every aopm_top
module aopm_top_chk #(parameter int DATA_W = 12) (
    // clock, reset, interrupt
    input wire logic              i_sys_clk,
    input wire logic              i_reset,
    input wire logic              o_irq,
    // enables and lvds legs
    input wire logic              o_primary_oe_n,
    input wire logic              o_secondary_oe_n,
    input wire logic              o_secondary_clk_oe_n,
    input wire logic              o_diff_oe_n,
    input wire logic [DATA_W-1:0] o_diff_data_pairs_p,
    input wire logic [DATA_W-1:0] o_diff_data_pairs_n,
    input wire logic              o_diff_overflow_pair_p,
    input wire logic              o_diff_overflow_pair_n,
    input wire logic              o_diff_data_valid_clock_p,
    input wire logic              o_diff_data_valid_clock_n
);
    default clocking @(posedge i_sys_clk); endclocking
    default disable iff (i_reset);
    chk_diff_data_legs: assert property (!o_diff_oe_n |->
        o_diff_data_pairs_n == ~o_diff_data_pairs_p) else $error("data legs");
    chk_diff_ovf_legs: assert property (!o_diff_oe_n |->
        o_diff_overflow_pair_n != o_diff_overflow_pair_p) else $error("ovf legs");
    chk_diff_clk_legs: assert property (!o_diff_oe_n |->
        o_diff_data_valid_clock_n != o_diff_data_valid_clock_p) else $error("clk");
    chk_sec_clk_on: assert property (!o_primary_oe_n |->
        !o_secondary_clk_oe_n) else $error("secondary clock released");
    chk_sec_needs_pri: assert property (!o_secondary_oe_n |->
        !o_primary_oe_n) else $error("secondary bus alone");
    chk_lvds_excl_cmos: assert property (!o_diff_oe_n |->
        o_primary_oe_n) else $error("lvds and cmos both driven");
    chk_reset_released: assert property ($past(i_reset) |->
        o_primary_oe_n && o_secondary_oe_n && o_diff_oe_n) else $error("oe");
    chk_irq_after_rst: assert property ($past(i_reset) |-> !o_irq)
        else $error("irq after reset");
    cover property (!o_secondary_oe_n);
    cover property (!o_diff_oe_n);
    cover property ($rose(o_irq));
endmodule
bind aopm_top aopm_top_chk #(.DATA_W(DATA_W)) u_chk (.*);

// *** tb_aopm_top.sv ***
// self-checking bench for the converter output port block
// assumes the capture model and checker are compiled first
module tb_aopm_top;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [7:0] CTL = aopm_pkg::CTRL_OFS;
    logic i_sys_clk = 0, i_reset = 1, i_encode_true_in = 0, i_encode_comp_in;
    logic i_wr = 0, i_rd = 0, i_sample_over = 1;
    logic [7:0] i_addr = 0;
    logic [31:0] i_wr_data = 0, o_rd_data;
    logic [11:0] i_sample_code = 12'h123, o_primary_data_bus;
    logic [11:0] o_secondary_data_bus, o_diff_data_pairs_p, o_diff_data_pairs_n;
    logic o_irq, o_primary_overflow_flag, o_primary_data_valid_clock;
    logic o_primary_oe_n, o_secondary_overflow_flag, o_secondary_oe_n;
    logic o_secondary_data_valid_clock, o_secondary_clk_oe_n, o_diff_oe_n;
    logic o_diff_overflow_pair_p, o_diff_overflow_pair_n, o_duty_stab_on;
    logic o_diff_data_valid_clock_p, o_diff_data_valid_clock_n;
    logic [12:0] pcap, lcap, scap;
    logic [1:0] ph = 0;
    int fail_count = 0, n_compared = 0, cyc = 0;
    assign i_encode_comp_in = ~i_encode_true_in;
    aopm_top dut (.*);
    aopm_capture u_pc (.i_clk(o_primary_data_valid_clock), .i_oe_n(o_primary_oe_n),
        .i_data(o_primary_data_bus), .i_ovf(o_primary_overflow_flag), .o_word(pcap));
    aopm_capture u_lc (.i_clk(o_diff_data_valid_clock_p), .i_oe_n(o_diff_oe_n),
        .i_data(o_diff_data_pairs_p), .i_ovf(o_diff_overflow_pair_p), .o_word(lcap));
    aopm_capture u_sc (.i_clk(o_secondary_data_valid_clock), .i_oe_n(o_secondary_oe_n),
        .i_data(o_secondary_data_bus), .i_ovf(o_secondary_overflow_flag), .o_word(scap));
    initial forever #50 i_sys_clk = ~i_sys_clk;
    // encode clock of 800 ns, timeout counter
    always @(posedge i_sys_clk) begin
        ph <= ph + 2'h1;
        if (ph == 2'h3) i_encode_true_in <= ~i_encode_true_in;
        cyc <= cyc + 1;
        if (cyc == 4000) begin
            fail_count++;
            final_report();
        end
    end
    task automatic cmp(input string s, input logic [31:0] e, input logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            fail_count++;
            $display("[ERR] %s exp %h got %h", s, e, g);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge i_sys_clk) begin i_wr <= 1; i_addr <= a; i_wr_data <= d; end
        @(posedge i_sys_clk) i_wr <= 0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
        @(posedge i_sys_clk) begin i_rd <= 1; i_addr <= a; end
        @(posedge i_sys_clk) i_rd <= 0;
        #1 cmp("rd", e, o_rd_data & m);
    endtask
    task automatic idle(input int n);
        repeat (n) @(posedge i_sys_clk);
        #1;
    endtask
    task automatic final_report;
        $display("compared %0d mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    initial begin
        repeat (2) @(posedge i_sys_clk);
        i_reset <= 0;
        rd(CTL, 32'h2, 32'h3F);
        rd(8'h10, 0, '1);
        for (int f = 0; f < 4; f++) begin
            wr(CTL, f << aopm_pkg::CTRL_FMT_LSB);
            idle(80);
            cmp("stab", f == 1 || f == 2, o_duty_stab_on);
            cmp("word", {1'b1, 12'h123 ^ (f > 1 ? 12'h800 : 12'h000)}, pcap);
            cmp("sec_clk_oe", 0, o_secondary_clk_oe_n);
        end
        for (int m = 1; m < 4; m++) begin
            wr(CTL, m << aopm_pkg::CTRL_MODE_LSB);
            idle(80);
            cmp("sec_oe", m == 3, o_secondary_oe_n);
            cmp("lvds_oe", m != 3, o_diff_oe_n);
            if (m == 2) cmp("sec_word", 13'h1123, scap);
        end
        cmp("lvds_word", 13'h1123, lcap);
        wr(aopm_pkg::INT_MASK_OFS, 1 << aopm_pkg::IRQ_OVERFLOW);
        idle(4);
        cmp("irq", 1, o_irq);
        wr(CTL, 1);
        idle(20);
        cmp("nap_oe", 1, o_primary_oe_n);
        wr(aopm_pkg::INT_STAT_OFS, '1);
        idle(4);
        cmp("irq_clr", 0, o_irq);
        final_report();
    end
endmodule
